/* shared/fm_ctrl_pkg.sv */
// How it works
// - Deviation setting comes from the low six bits of the deviation register.
// - Bits 4..0 pick a gain step; bit 5 set halves the nominal deviation.
// - Codes 00000..00010 are not for normal use; code 00011 is calibration.
// - After reset the deviation field holds step 10101 with halving bit set.
// - Synthesis start: bit 2 high, bits 3, 4, 5 low in switch control.
// - Ten-bit frequency code is frequency register plus switch-control bits 7..6.
// - VCO target frequency equals the ten-bit code times 10 kHz.
// - Loop close: bit 4 high, bit 2 low; right channel keeps deviation.
package fm_ctrl_pkg;
	localparam int             ADDR_W          = 8;
	localparam int             DATA_W          = 32;
	localparam int             CODE_W          = 10;
	localparam int             KHZ_W           = 14;
	localparam logic [7:0]     IDX_DEVIATION   = 8'h05;
	localparam logic [7:0]     IDX_SWITCH      = 8'h06;
	localparam logic [7:0]     IDX_FREQUENCY   = 8'h07;
	localparam logic [7:0]     IDX_STATUS      = 8'h08;
	localparam logic [7:0]     RST_DEVIATION   = 8'h35;
	localparam logic [7:0]     RST_SWITCH      = 8'h00;
	localparam logic [7:0]     RST_FREQUENCY   = 8'h00;
	localparam int             DEV_HALF_BIT    = 5;
	localparam int             SW_DRIVE_BIT    = 2;
	localparam int             SW_SECBIAS_BIT  = 3;
	localparam int             SW_PDPATH_BIT   = 4;
	localparam int             SW_AUX_BIT      = 5;
	localparam int             SW_CODE_LO_BIT  = 6;
	localparam logic [4:0]     DEV_LAST_UNUSED = 5'h02;
	localparam logic [4:0]     DEV_CAL_STEP    = 5'h03;
	localparam logic [KHZ_W-1:0] STEP_KHZ      = 14'h000A;
	localparam logic [CODE_W-1:0] CODE_MIN     = 10'h1F4;
	localparam logic [CODE_W-1:0] CODE_MAX     = 10'h3E8;
endpackage

/* shared/synth_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface synth_if;
	logic [9:0]  code;
	logic [13:0] target_khz;
	logic        in_range;
	modport ctrl  (output code, input target_khz, input in_range);
	modport tuner (input code, output target_khz, output in_range);
endinterface
`default_nettype wire

/* hw/synth_tuner.sv */
`timescale 1ns/1ps
`default_nettype none
module synth_tuner
	import fm_ctrl_pkg::*;
(
	input  wire logic  pclk,
	input  wire logic  presetn,
	synth_if.tuner     syn
);
	logic [KHZ_W-1:0] khz_q;
	logic [KHZ_W-1:0] khz_d;
	logic             range_q;
	logic             range_d;

	// Code times ten as shift and add
	always_comb begin
		khz_d   = KHZ_W'(({4'h0, syn.code} << 3) + ({4'h0, syn.code} << 1));
		range_d = (syn.code >= CODE_MIN) && (syn.code <= CODE_MAX);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			khz_q   <= '0;
			range_q <= 1'b0;
		end else begin
			khz_q   <= khz_d;
			range_q <= range_d;
		end
	end

	assign syn.target_khz = khz_q;
	assign syn.in_range   = range_q;
endmodule
`default_nettype wire

/* hw/fm_demod_synth_control.sv */
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module fm_demod_synth_control
	import fm_ctrl_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [4:0]        dev_gain_step,
	output logic                   dev_half_scale,
	output logic                   dev_cal_setting,
	output logic                   dev_code_unusable,
	output logic                   synth_drive_switch,
	output logic                   secondary_bias_switch,
	output logic                   phase_detector_path_switch,
	output logic                   auxiliary_path_switch,
	output logic      [CODE_W-1:0] synth_frequency_code_out,
	output logic      [KHZ_W-1:0]  vco_target_khz,
	output logic                   code_in_range
);
	synth_if syn ();

	logic [7:0]        dev_q;
	logic [7:0]        dev_d;
	logic [7:0]        sw_q;
	logic [7:0]        sw_d;
	logic [7:0]        freq_q;
	logic [7:0]        freq_d;
	logic              pready_q;
	logic              pready_d;
	logic              pslverr_q;
	logic              pslverr_d;
	logic [DATA_W-1:0] prdata_q;
	logic [DATA_W-1:0] prdata_d;
	logic [4:0]        step_q;
	logic [4:0]        step_d;
	logic              half_q;
	logic              half_d;
	logic              cal_q;
	logic              cal_d;
	logic              unusable_q;
	logic              unusable_d;
	logic [3:0]        sw_out_q;
	logic [3:0]        sw_out_d;
	logic [CODE_W-1:0] code_q;
	logic [CODE_W-1:0] code_d;
	logic [7:0]        index;
	logic              mapped;
	logic              access;
	logic              commit;
	logic [7:0]        rd_byte;

	// Word index from byte address; low two bits must be zero
	always_comb begin
		index   = {2'b00, paddr[ADDR_W-1:2]};
		mapped  = (paddr[1:0] == 2'b00) && ((index == IDX_DEVIATION) || (index == IDX_SWITCH)
			|| (index == IDX_FREQUENCY) || (index == IDX_STATUS));
		access  = psel && penable && !pready_q;
		commit  = psel && penable && pready_q;
	end

	// Read mux
	always_comb begin
		case (index)
			IDX_DEVIATION: rd_byte = dev_q;
			IDX_SWITCH:    rd_byte = sw_q;
			IDX_FREQUENCY: rd_byte = freq_q;
			IDX_STATUS:    rd_byte = {5'h00, code_in_range, cal_q, unusable_q};
			default:       rd_byte = 8'h00;
		endcase
	end

	// Bus handshake: one wait state, answer registered
	always_comb begin
		pready_d  = access;
		pslverr_d = access && !mapped;
		prdata_d  = prdata_q;
		if (access) begin
			prdata_d = (!pwrite && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// Register file writes take effect at the completing edge
	always_comb begin
		dev_d  = dev_q;
		sw_d   = sw_q;
		freq_d = freq_q;
		if (commit && pwrite && !pslverr_q) begin
			case (index)
				IDX_DEVIATION: dev_d  = pwdata[7:0];
				IDX_SWITCH:    sw_d   = pwdata[7:0];
				IDX_FREQUENCY: freq_d = pwdata[7:0];
				default: begin
					dev_d = dev_q;
				end
			endcase
		end
	end

	// Decoded outputs follow the registers one clock later
	always_comb begin
		step_d     = dev_q[4:0];
		half_d     = dev_q[DEV_HALF_BIT];
		cal_d      = (dev_q[4:0] == DEV_CAL_STEP);
		unusable_d = (dev_q[4:0] <= DEV_LAST_UNUSED);
		sw_out_d   = {sw_q[SW_AUX_BIT], sw_q[SW_PDPATH_BIT],
			sw_q[SW_SECBIAS_BIT], sw_q[SW_DRIVE_BIT]};
		code_d     = {sw_q[SW_CODE_LO_BIT+1], sw_q[SW_CODE_LO_BIT], freq_q};
	end

	// Bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	// Register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_q  <= RST_DEVIATION;
			sw_q   <= RST_SWITCH;
			freq_q <= RST_FREQUENCY;
		end else begin
			dev_q  <= dev_d;
			sw_q   <= sw_d;
			freq_q <= freq_d;
		end
	end

	// Decoded outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_q     <= RST_DEVIATION[4:0];
			half_q     <= RST_DEVIATION[DEV_HALF_BIT];
			cal_q      <= 1'b0;
			unusable_q <= 1'b0;
			sw_out_q   <= 4'h0;
			code_q     <= '0;
		end else begin
			step_q     <= step_d;
			half_q     <= half_d;
			cal_q      <= cal_d;
			unusable_q <= unusable_d;
			sw_out_q   <= sw_out_d;
			code_q     <= code_d;
		end
	end

	assign syn.code = code_q;

	synth_tuner u_tuner (
		.pclk    (pclk),
		.presetn (presetn),
		.syn     (syn.tuner)
	);

	assign prdata                     = prdata_q;
	assign pready                     = pready_q;
	assign pslverr                    = pslverr_q;
	assign dev_gain_step              = step_q;
	assign dev_half_scale             = half_q;
	assign dev_cal_setting            = cal_q;
	assign dev_code_unusable          = unusable_q;
	assign synth_drive_switch         = sw_out_q[0];
	assign secondary_bias_switch      = sw_out_q[1];
	assign phase_detector_path_switch = sw_out_q[2];
	assign auxiliary_path_switch      = sw_out_q[3];
	assign synth_frequency_code_out   = code_q;
	assign vco_target_khz             = syn.target_khz;
	assign code_in_range              = syn.in_range;
endmodule
`default_nettype wire

/* verification/fm_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module fm_ctrl_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [4:0]  dev_gain_step,
	input wire logic        dev_half_scale,
	input wire logic        dev_cal_setting,
	input wire logic        dev_code_unusable,
	input wire logic        synth_drive_switch,
	input wire logic        secondary_bias_switch,
	input wire logic        phase_detector_path_switch,
	input wire logic        auxiliary_path_switch,
	input wire logic [9:0]  synth_frequency_code_out,
	input wire logic [13:0] vco_target_khz
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic w = psel && penable && pready && !pslverr && pwrite;
	wire logic [9:0] c = synth_frequency_code_out;
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready");
	ready_time_a: assert property (psel && !penable |-> ##2 pready) else $error("late");
	dev_write_a: assert property (w && paddr == 8'h14 |-> ##2
		{dev_half_scale, dev_gain_step} == $past(pwdata[5:0], 2)) else $error("dev");
	cal_flag_a: assert property ((dev_gain_step == 3)[*2] |-> dev_cal_setting)
		else $error("cal");
	unused_flag_a: assert property ((dev_gain_step <= 2)[*2] |-> dev_code_unusable)
		else $error("unusable");
	switch_write_a: assert property (w && paddr == 8'h18 |-> ##2 {c[9:8], auxiliary_path_switch,
		phase_detector_path_switch, secondary_bias_switch, synth_drive_switch}
		== $past(pwdata[7:2], 2)) else $error("switch");
	freq_write_a: assert property (w && paddr == 8'h1c |-> ##2
		c[7:0] == $past(pwdata[7:0], 2)) else $error("code");
	khz_value_a: assert property (vco_target_khz == 14'($past(c)) * 14'd10)
		else $error("khz");
	cover property (w);
	cover property (pslverr);
	cover property (dev_cal_setting);
endmodule
bind fm_demod_synth_control fm_ctrl_chk chk (
	.pclk                       (pclk),
	.presetn                    (presetn),
	.psel                       (psel),
	.penable                    (penable),
	.pwrite                     (pwrite),
	.pready                     (pready),
	.pslverr                    (pslverr),
	.paddr                      (paddr),
	.pwdata                     (pwdata),
	.dev_gain_step              (dev_gain_step),
	.dev_half_scale             (dev_half_scale),
	.dev_cal_setting            (dev_cal_setting),
	.dev_code_unusable          (dev_code_unusable),
	.synth_drive_switch         (synth_drive_switch),
	.secondary_bias_switch      (secondary_bias_switch),
	.phase_detector_path_switch (phase_detector_path_switch),
	.auxiliary_path_switch      (auxiliary_path_switch),
	.synth_frequency_code_out   (synth_frequency_code_out),
	.vco_target_khz             (vco_target_khz)
);
`default_nettype wire

/* verification/apb_host.sv */
`timescale 1ns/1ps
`default_nettype none
module apb_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata
);
	logic hung = 1'b0;
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// Request held until pready is sampled high
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready)
				break;
		end
		if (n == 20) begin
			hung = 1'b1;
			tb_fm_demod_synth_control.end_of_test();
		end else begin
			rd = prdata;
			err = pslverr;
			{psel, penable} <= 2'b00;
		end
	endtask
endmodule
`default_nettype wire

/* verification/tb_fm_demod_synth_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_fm_demod_synth_control;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, err, dev_half_scale, dev_cal_setting;
	logic dev_code_unusable, synth_drive_switch, secondary_bias_switch, code_in_range;
	logic phase_detector_path_switch, auxiliary_path_switch;
	logic [4:0] dev_gain_step;
	logic [7:0] paddr;
	logic [9:0] synth_frequency_code_out;
	logic [13:0] vco_target_khz;
	logic [31:0] pwdata, prdata, rd, lfsr = 32'hb6ed;
	int miscompares = 0;
	int checks_done = 0;
	int m[5:7] = '{8'h35, 0, 0};
	int q[$] = '{702, 720, 600, 600, 499, 1001, 500, 1000, 0};
	int d[3] = '{8'h02, 8'h23, 8'h24};
	fm_demod_synth_control dut (
		.pclk                       (pclk),
		.presetn                    (presetn),
		.psel                       (psel),
		.penable                    (penable),
		.pwrite                     (pwrite),
		.paddr                      (paddr),
		.pwdata                     (pwdata),
		.prdata                     (prdata),
		.pready                     (pready),
		.pslverr                    (pslverr),
		.dev_gain_step              (dev_gain_step),
		.dev_half_scale             (dev_half_scale),
		.dev_cal_setting            (dev_cal_setting),
		.dev_code_unusable          (dev_code_unusable),
		.synth_drive_switch         (synth_drive_switch),
		.secondary_bias_switch      (secondary_bias_switch),
		.phase_detector_path_switch (phase_detector_path_switch),
		.auxiliary_path_switch      (auxiliary_path_switch),
		.synth_frequency_code_out   (synth_frequency_code_out),
		.vco_target_khz             (vco_target_khz),
		.code_in_range              (code_in_range)
	);
	apb_host host (
		.pclk    (pclk),
		.pready  (pready),
		.pslverr (pslverr),
		.prdata  (prdata),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata)
	);
	always #5 pclk = ~pclk;
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [31:0] seen, exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, b);
		lfsr = nx(lfsr);
		host.xfer(1'b1, a, {lfsr[31:8], b}, rd, err);
		check(err, !(a inside {8'h14, 8'h18, 8'h1c, 8'h20}), "pslverr");
		if (a inside {8'h14, 8'h18, 8'h1c})
			m[a[4:2]] = b;
	endtask
	task automatic cmp;
		int c;
		logic [2:0] s;
		c = {m[6][7:6], m[7][7:0]};
		s = {c >= 500 && c <= 1000, m[5][4:0] == 3, m[5][4:0] <= 2};
		repeat (2) @(posedge pclk);
		#1;
		check({dev_half_scale, dev_gain_step}, m[5][5:0], "step");
		check({code_in_range, dev_cal_setting, dev_code_unusable}, s, "flags");
		check({auxiliary_path_switch, phase_detector_path_switch, secondary_bias_switch,
			synth_drive_switch}, m[6][5:2], "switch");
		check({vco_target_khz, synth_frequency_code_out}, {14'(c * 10), 10'(c)}, "code");
		for (int i = 5; i < 9; i++) begin
			host.xfer(1'b0, 8'(i * 4), 0, rd, err);
			check(rd, i < 8 ? m[i] : s, "read");
		end
	endtask
	task automatic end_of_test;
		miscompares += host.hung;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		cmp();
		$display("reset test done");
		foreach (q[i]) begin
			if (!i[0])
				wr(8'h14, i < 6 ? 8'(d[i / 2]) : lfsr[7:0]);
			if (q[i] == 0)
				q[i] = 500 + lfsr % 501;
			wr(8'h18, {q[i][9:8], 6'h04});
			wr(8'h1c, q[i][7:0]);
			cmp();
			wr(8'h18, {q[i][9:8], i[0] ? 6'h20 : 6'h10});
			cmp();
		end
		$display("synthesis test done");
		wr(8'h24, 8'h55);
		wr(8'h15, 8'h55);
		wr(8'h20, 8'h55);
		host.xfer(1'b0, 8'h24, 0, rd, err);
		check(rd, 0, "unmapped");
		check(err, 1, "read pslverr");
		cmp();
		$display("address test done");
		end_of_test();
	end
endmodule
`default_nettype wire
